// *** include/mpl_pkg.sv ***
package mpl_pkg;

  // ----------------------------------------------------------------
  // Sizes and packet codes
  // ----------------------------------------------------------------
  localparam int MEM_BYTES = 16;
  localparam int UID_WORDS = 3;
  localparam logic [3:0] UID_MAX = 4'hA;
  localparam logic [3:0] MEM_LAST = 4'hF;
  localparam logic [3:0] EVT_HEAD_LAST = 4'h2;
  localparam logic [3:0] UID_FIRST_IDX = 4'h3;
  localparam logic [7:0] EVT_CODE = 8'h08;
  localparam logic [7:0] CMD_SLEEP = 8'h03;
  localparam logic [7:0] WAKE_BYTE = 8'h00;
  localparam logic [7:0] ACK_CODE = 8'h01;
  localparam logic [7:0] START_CODE = 8'h0F;
  localparam logic [7:0] MEM_DEFAULT = 8'h00;
  localparam logic [63:0] PW_DEFAULT = 64'h0000_0000_0000_0000;
  localparam logic [15:0] STARTUP_CYCLES = 16'h0010;

  // ----------------------------------------------------------------
  // Event flag byte layout
  // ----------------------------------------------------------------
  localparam int EV_POLL = 6;
  localparam int EV_CMD = 5;
  localparam int EV_COMP = 4;
  localparam int EV_IO0 = 0;
  localparam logic [6:0] EV_ALWAYS = 7'h20;
  localparam logic [6:0] EV_SLEEP_WAKE = 7'h1F;
  localparam logic [6:0] EV_MASK_RESET = 7'h00;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EVMASK = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PASS_LO = 8'h0C;
  localparam logic [7:0] ADDR_PASS_HI = 8'h10;
  localparam logic [7:0] ADDR_TAG_LEN = 8'h14;
  localparam logic [7:0] ADDR_UID0 = 8'h18;
  localparam logic [7:0] ADDR_UID1 = 8'h1C;
  localparam logic [7:0] ADDR_UID2 = 8'h20;
  localparam logic [7:0] ADDR_ANALOG = 8'h24;
  localparam logic [1:0] MEM_REGION = 2'h1;
  localparam int CTRL_UNLOCK = 0;
  localparam int CTRL_LOCK = 1;
  localparam int CTRL_SETPW = 2;
  localparam int AN_DAC = 0;
  localparam int AN_COMP = 1;
  localparam int ST_LOCKED = 7;
  localparam int ST_COPY = 8;
  localparam int ST_STATE_LSB = 12;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_SLEEP_ACK = 3'b001,
    ST_SLEEP = 3'b010,
    ST_SLEEP_EVT = 3'b011,
    ST_WAKE_ACK = 3'b100,
    ST_PD_PREP = 3'b101,
    ST_PDOWN = 3'b110,
    ST_RESTART = 3'b111
  } mpl_state_t;

  typedef enum logic [1:0] {
    TX_EVENT = 2'b00,
    TX_ACK = 2'b01,
    TX_START = 2'b10
  } mpl_txkind_t;

endpackage

// *** logic/mpl_power_ctrl.sv ***
// Overview of operation
// - Event packets start with response byte 0x08, then parameter bytes.
// - Flag byte: bit6 polling, bit5 command done, bit4 comparator, bits3-0 IO edges.
// - Polling, comparator and IO events maskable; command-done event always on.
// - Flag byte followed by tag id length, then that many id bytes.
// - Sleep command 0x03 answered by bare acknowledge, then sleep.
// - Byte 0x00 wakes device; acknowledge sent when ready.
// - Waking from sleep keeps all state; no restart.
// - Sleep stops communication and PWM; DAC and comparator keep running.
// - Enabled comparator or IO events wake briefly, send packets, resleep.
// - Request low: prepare, drive indicator low just before power-down.
// - Request high: restart with indicator low, then high plus start packet.
// - Restart from power-down reinitialises all volatile state.
// - Ongoing transfer or command finishes before power-down.
// - Power-down: all off, IOs high impedance, outside ignored.
// - Memory guarded by 8-byte password, locked at power-up, default zeros.
// - Locked memory reads hidden, writes discarded.
// - Unlock copies non-volatile to volatile; lock writes changes back.
// - Commands read volatile copy when unlocked, non-volatile when locked.
// - Active-low indicator asserted in sleep or power-down.
// - Request low during non-power-up reset restores memory defaults.
`timescale 1ns/1ns
`default_nettype none

module mpl_power_ctrl
  import mpl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic powerOnReset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_request_n,
  input wire logic comparatorOut,
  input wire logic [3:0] ioPin,
  input wire logic pollingEvent,
  input wire logic commandDone,
  input wire logic commandBusy,
  input wire logic linkBusy,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  input wire logic [3:0] cmdMemAddr,
  output logic [7:0] cmdMemData,
  output logic low_power_indicator_n,
  output logic commEnable,
  output logic pwmEnable,
  output logic current_output_dac,
  output logic comparatorEnable,
  output logic ioHighZ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mpl_state_t state, next_state;
  mpl_txkind_t txKind, next_txKind;
  logic pdMeta, pdReqN;
  logic [4:0] pinMeta, pinLevel, pinLast;
  logic [6:0] flags, evMask, evSet, snapFlags, flagClear;
  logic wipe, awake, ackLaunched, txLaunch, txDoneLast;
  logic [15:0] startCount;
  logic [3:0] txIdx, txLast, tagIdLength;
  logic [31:0] uidWord [UID_WORDS];
  logic [7:0] volMem [MEM_BYTES];
  logic [7:0] nvMem [MEM_BYTES];
  logic [63:0] password, attempt;
  logic locked, copyBusy, copyToVol;
  logic [3:0] copyIdx;
  logic coldBoot, strapCheck, restoreGo;
  logic dacCfg, compCfg;
  logic apbAccess, apbFirst, writeEn, addrBad, memHit;
  logic [3:0] memIdx;
  logic [31:0] readMux;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (clockEnable) begin
      pdMeta <= power_down_request_n;
      pdReqN <= pdMeta;
      pinMeta <= {comparatorOut, ioPin};
      pinLevel <= pinMeta;
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  assign wipe = rst || (state == ST_RESTART);
  assign awake = (state != ST_PDOWN) && (state != ST_RESTART);
  assign evSet = awake ? ({pollingEvent, commandDone, pinLevel ^ pinLast}
                          & (evMask | EV_ALWAYS)) : 7'h00;
  assign flagClear = txDoneLast && (txKind == TX_EVENT) ? snapFlags : 7'h00;

  always_ff @(posedge clock) begin
    if (wipe) begin
      flags <= 7'h00;
      pinLast <= pinLevel;
    end else if (clockEnable) begin
      pinLast <= pinLevel;
      flags <= (flags & ~flagClear) | evSet;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (!pdReqN) next_state = ST_PD_PREP;
        else if (rxValid && rxData == CMD_SLEEP) next_state = ST_SLEEP_ACK;
      end
      ST_SLEEP_ACK: begin
        if (!pdReqN) next_state = ST_PD_PREP;
        else if (ackLaunched && !txValid) next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!pdReqN) next_state = ST_PD_PREP;
        else if (rxValid && rxData == WAKE_BYTE) next_state = ST_WAKE_ACK;
        else if (|(flags & EV_SLEEP_WAKE)) next_state = ST_SLEEP_EVT;
      end
      ST_SLEEP_EVT: begin
        if (!pdReqN) next_state = ST_PD_PREP;
        else if (flags == 7'h00 && !txValid) next_state = ST_SLEEP;
      end
      ST_WAKE_ACK: begin
        if (!pdReqN) next_state = ST_PD_PREP;
        else if (ackLaunched && !txValid) next_state = ST_RUN;
      end
      ST_PD_PREP: begin
        if (!txValid && !linkBusy && !commandBusy && !copyBusy) begin
          next_state = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        if (pdReqN) next_state = ST_RESTART;
      end
      ST_RESTART: begin
        if (startCount == 16'h0000) next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_RESTART;
      startCount <= STARTUP_CYCLES;
      ackLaunched <= 1'b0;
    end else if (clockEnable) begin
      state <= next_state;
      if (next_state == ST_RESTART && state != ST_RESTART) startCount <= STARTUP_CYCLES;
      else if (state == ST_RESTART && startCount != 16'h0000) startCount <= startCount - 16'h0001;
      if (next_state != state) ackLaunched <= 1'b0;
      else if (txLaunch && next_txKind == TX_ACK) ackLaunched <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Packet transmitter
  // ----------------------------------------------------------------
  always_comb begin
    txLaunch = 1'b0;
    next_txKind = TX_EVENT;
    if (!txValid) begin
      if (state == ST_RESTART && startCount == 16'h0000) begin
        txLaunch = 1'b1;
        next_txKind = TX_START;
      end else if ((state == ST_SLEEP_ACK || state == ST_WAKE_ACK) && !ackLaunched) begin
        txLaunch = 1'b1;
        next_txKind = TX_ACK;
      end else if ((state == ST_RUN || state == ST_SLEEP_EVT) && flags != 7'h00) begin
        txLaunch = 1'b1;
        next_txKind = TX_EVENT;
      end
    end
  end

  assign txDoneLast = txValid && txReady && (txIdx == txLast);

  function automatic logic [7:0] byteAt(input logic [3:0] idx);
    logic [3:0] u;
    u = idx - UID_FIRST_IDX;
    if (idx == 4'h1) byteAt = {1'b0, snapFlags};
    else if (idx == EVT_HEAD_LAST) byteAt = {4'h0, tagIdLength};
    else byteAt = uidWord[u[3:2]][{u[1:0], 3'b000} +: 8];
  endfunction

  always_ff @(posedge clock) begin
    if (rst) begin
      txValid <= 1'b0;
      txData <= 8'h00;
      txKind <= TX_EVENT;
      txIdx <= 4'h0;
      txLast <= 4'h0;
      snapFlags <= 7'h00;
    end else if (clockEnable) begin
      if (txLaunch) begin
        txValid <= 1'b1;
        txKind <= next_txKind;
        txIdx <= 4'h0;
        snapFlags <= flags;
        unique case (next_txKind)
          TX_EVENT: begin
            txData <= EVT_CODE;
            txLast <= EVT_HEAD_LAST + tagIdLength;
          end
          TX_ACK: begin
            txData <= ACK_CODE;
            txLast <= 4'h0;
          end
          default: begin
            txData <= START_CODE;
            txLast <= 4'h0;
          end
        endcase
      end else if (txValid && txReady) begin
        if (txDoneLast) begin
          txValid <= 1'b0;
        end else begin
          txIdx <= txIdx + 4'h1;
          txData <= byteAt(txIdx + 4'h1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Low power outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      low_power_indicator_n <= 1'b0;
      commEnable <= 1'b0;
      pwmEnable <= 1'b0;
      current_output_dac <= 1'b0;
      comparatorEnable <= 1'b0;
      ioHighZ <= 1'b0;
    end else if (clockEnable) begin
      low_power_indicator_n <= !(next_state inside {ST_SLEEP, ST_SLEEP_EVT, ST_PDOWN,
                                                    ST_RESTART});
      commEnable <= !(next_state inside {ST_SLEEP, ST_PDOWN, ST_RESTART});
      pwmEnable <= next_state inside {ST_RUN, ST_SLEEP_ACK, ST_WAKE_ACK, ST_PD_PREP};
      current_output_dac <= dacCfg && !(next_state inside {ST_PDOWN, ST_RESTART});
      comparatorEnable <= compCfg && !(next_state inside {ST_PDOWN, ST_RESTART});
      ioHighZ <= (next_state == ST_PDOWN);
    end
  end

  // ----------------------------------------------------------------
  // Default restore strap
  // ----------------------------------------------------------------
  assign restoreGo = strapCheck && !pdReqN && !coldBoot;

  always_ff @(posedge clock) begin
    if (rst) begin
      coldBoot <= powerOnReset;
      strapCheck <= 1'b1;
    end else if (clockEnable) begin
      strapCheck <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Memory lock and copy engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (wipe) begin
      locked <= 1'b1;
      copyBusy <= 1'b0;
      copyToVol <= 1'b0;
      copyIdx <= 4'h0;
    end else if (clockEnable) begin
      if (copyBusy) begin
        copyIdx <= copyIdx + 4'h1;
        if (copyIdx == MEM_LAST) begin
          copyBusy <= 1'b0;
          locked <= !copyToVol;
        end
      end else if (writeEn && paddr == ADDR_CTRL) begin
        if (pwdata[CTRL_UNLOCK] && locked && attempt == password) begin
          copyBusy <= 1'b1;
          copyToVol <= 1'b1;
          copyIdx <= 4'h0;
        end else if (pwdata[CTRL_LOCK] && !locked) begin
          copyBusy <= 1'b1;
          copyToVol <= 1'b0;
          copyIdx <= 4'h0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (wipe) begin
      for (int i = 0; i < MEM_BYTES; i++) volMem[i] <= MEM_DEFAULT;
    end else if (clockEnable) begin
      if (copyBusy && copyToVol) volMem[copyIdx] <= nvMem[copyIdx];
      else if (writeEn && memHit && !locked) volMem[memIdx] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (clockEnable) begin
      if (restoreGo) begin
        for (int i = 0; i < MEM_BYTES; i++) nvMem[i] <= MEM_DEFAULT;
        password <= PW_DEFAULT;
      end else begin
        if (copyBusy && !copyToVol) nvMem[copyIdx] <= volMem[copyIdx];
        if (writeEn && paddr == ADDR_CTRL && pwdata[CTRL_SETPW] && !locked) begin
          password <= attempt;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmdMemData <= 8'h00;
    end else if (clockEnable) begin
      cmdMemData <= locked ? nvMem[cmdMemAddr] : volMem[cmdMemAddr];
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (wipe) begin
      evMask <= EV_MASK_RESET;
      tagIdLength <= 4'h0;
      attempt <= PW_DEFAULT;
      dacCfg <= 1'b0;
      compCfg <= 1'b0;
      for (int i = 0; i < UID_WORDS; i++) uidWord[i] <= 32'h0000_0000;
    end else if (clockEnable && writeEn) begin
      unique case (paddr)
        ADDR_EVMASK: evMask <= pwdata[6:0] & ~EV_ALWAYS;
        ADDR_PASS_LO: attempt[31:0] <= pwdata;
        ADDR_PASS_HI: attempt[63:32] <= pwdata;
        ADDR_TAG_LEN: tagIdLength <= (pwdata[3:0] > UID_MAX) ? UID_MAX : pwdata[3:0];
        ADDR_UID0: uidWord[0] <= pwdata;
        ADDR_UID1: uidWord[1] <= pwdata;
        ADDR_UID2: uidWord[2] <= pwdata;
        ADDR_ANALOG: begin
          dacCfg <= pwdata[AN_DAC];
          compCfg <= pwdata[AN_COMP];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apbAccess = psel && penable;
  assign apbFirst = apbAccess && !pready;
  assign writeEn = apbAccess && pready && pwrite && !pslverr && !copyBusy;
  assign memHit = (paddr[7:6] == MEM_REGION);
  assign memIdx = paddr[5:2];

  always_comb begin
    readMux = 32'h0000_0000;
    addrBad = 1'b0;
    if (memHit) begin
      readMux = locked ? 32'h0000_0000 : {24'h00_0000, volMem[memIdx]};
    end else begin
      unique case (paddr)
        ADDR_CTRL, ADDR_PASS_LO, ADDR_PASS_HI: readMux = 32'h0000_0000;
        ADDR_EVMASK: readMux = {25'h000_0000, evMask};
        ADDR_STATUS: begin
          readMux[6:0] = flags;
          readMux[ST_LOCKED] = locked;
          readMux[ST_COPY] = copyBusy;
          readMux[ST_STATE_LSB +: 3] = state;
        end
        ADDR_TAG_LEN: readMux = {28'h000_0000, tagIdLength};
        ADDR_UID0: readMux = uidWord[0];
        ADDR_UID1: readMux = uidWord[1];
        ADDR_UID2: readMux = uidWord[2];
        ADDR_ANALOG: readMux = {30'h0000_0000, compCfg, dacCfg};
        default: addrBad = 1'b1;
      endcase
    end
    if (paddr[1:0] != 2'b00 || state == ST_PDOWN) addrBad = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clockEnable) begin
      pready <= apbFirst;
      if (apbFirst) begin
        prdata <= (pwrite || addrBad) ? 32'h0000_0000 : readMux;
        pslverr <= addrBad;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst || !clockEnable);

  chk_event_header: assert property (txLaunch && next_txKind == TX_EVENT |=>
    txValid && txData == EVT_CODE) else $error("event packet header wrong");
  chk_cmd_always: assert property (commandDone && awake |=> flags[EV_CMD])
    else $error("command done flag missing");
  chk_sleep_ack: assert property (state == ST_RUN && pdReqN && rxValid &&
    rxData == CMD_SLEEP |=> state == ST_SLEEP_ACK ##[1:20] txValid && txData == ACK_CODE)
    else $error("sleep command not acknowledged");
  chk_wake_byte: assert property (state == ST_SLEEP && pdReqN && rxValid &&
    rxData == WAKE_BYTE |=> state == ST_WAKE_ACK) else $error("wake byte ignored");
  chk_sleep_quiet: assert property (state == ST_SLEEP && $past(state) == ST_SLEEP |->
    !pwmEnable && !commEnable) else $error("sleep left comm or pwm on");
  chk_pd_wait: assert property (state == ST_PD_PREP &&
    (linkBusy || commandBusy || txValid) |=> state == ST_PD_PREP)
    else $error("power down entered while busy");
  chk_pd_highz: assert property (state == ST_PDOWN && $past(state) == ST_PDOWN |->
    ioHighZ && !commEnable && !pwmEnable) else $error("power down outputs active");
  chk_locked_read: assert property (apbFirst && !pwrite && memHit && locked |=>
    pready && prdata == 32'h0000_0000) else $error("locked memory visible");
  chk_indicator: assert property ($past(state) inside {ST_SLEEP, ST_PDOWN} &&
    state == $past(state) |-> !low_power_indicator_n) else $error("indicator not asserted");
  chk_restart_wipe: assert property (state == ST_RESTART |=> flags == 7'h00 && locked)
    else $error("volatile state kept");
  chk_flags_clear: assert property (txDoneLast && txKind == TX_EVENT && evSet == 7'h00
    |=> (flags & snapFlags) == 7'h00) else $error("event flags not cleared");

endmodule

`default_nettype wire

// *** tb/mpl_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module mpl_host_model (
  input wire logic clock,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxData
);
  logic [7:0] got[$];
  logic stall = 1'b0;
  logic [3:0] k = 4'h0;

  initial begin
    txReady = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
  end

  // Collect bytes, stalling every other cycle when asked
  always @(posedge clock) begin
    k <= k + 4'h1;
    if (txValid && txReady) begin
      got.push_back(txData);
    end
    txReady <= !stall || k[0];
  end

  // One UART byte; the data line no longer shows it afterwards
  task send(input logic [7:0] b);
    rxValid <= 1'b1;
    rxData <= b;
    @(posedge clock);
    rxValid <= 1'b0;
    rxData <= ~b;
  endtask
endmodule

`default_nettype wire

// *** tb/mpl_power_ctrl_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module mpl_power_ctrl_tb import mpl_pkg::*; ;
  logic clock, rst, powerOnReset, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, rxData, txData, cmdMemData;
  logic [31:0] pwdata, prdata, rd;
  logic pollingEvent, commandDone, linkBusy, rxValid, txValid, txReady;
  logic commandBusy, comparatorOut;
  logic [3:0] ioPin, cmdMemAddr;
  logic power_down_request_n, low_power_indicator_n, commEnable, pwmEnable, dac, comp, ioHighZ;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  mpl_power_ctrl mpl_power_ctrl_i (.clock(clock), .rst(rst), .clockEnable(1'b1),
    .powerOnReset(powerOnReset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_request_n(power_down_request_n), .comparatorOut(comparatorOut), .ioPin(ioPin),
    .pollingEvent(pollingEvent), .commandDone(commandDone), .commandBusy(commandBusy),
    .linkBusy(linkBusy), .rxValid(rxValid), .rxData(rxData), .txData(txData),
    .txValid(txValid), .txReady(txReady), .cmdMemAddr(cmdMemAddr), .cmdMemData(cmdMemData),
    .low_power_indicator_n(low_power_indicator_n), .commEnable(commEnable),
    .pwmEnable(pwmEnable), .current_output_dac(dac), .comparatorEnable(comp),
    .ioHighZ(ioHighZ));

  mpl_host_model mpl_host_model_i (.clock(clock), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxValid(rxValid), .rxData(rxData));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the global cycle ceiling ends this wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task pkt(input logic [63:0] v, input int n);
    int i;
    i = 0;
    while (mpl_host_model_i.got.size() < n && i < 400) begin
      @(posedge clock);
      i++;
    end
    repeat (4) @(posedge clock);
    chk(mpl_host_model_i.got.size(), n);
    for (i = 0; i < n; i++) chk(mpl_host_model_i.got[i], v[8*(n-1-i)+:8]);
    mpl_host_model_i.got.delete();
  endtask

  task pulse(input logic cmd);
    if (cmd) commandDone <= 1'b1;
    else pollingEvent <= 1'b1;
    @(posedge clock);
    commandDone <= 1'b0;
    pollingEvent <= 1'b0;
  endtask

  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_restore;
    repeat (9) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk(low_power_indicator_n, 1'b0);
    power_down_request_n <= 1'b1;
    pkt(64'h0000_0000_0000_000F, 1);
    chk({low_power_indicator_n, commEnable}, 2'h3);
  endtask

  task s_memory;
    apb(0, ADDR_STATUS, 0);
    chk(rd[ST_LOCKED], 1'b1);
    apb(1, 8'h40, 32'h0000_005A);
    apb(0, 8'h40, 0);
    chk(rd, 0);
    apb(0, 8'h30, 0);
    chk(er, 1'b1);
    apb(1, ADDR_PASS_LO, 32'h0000_0001);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clock);
    apb(0, ADDR_STATUS, 0);
    chk(rd[ST_LOCKED], 1'b1);
    apb(1, ADDR_PASS_LO, 32'h0000_0000);
    apb(1, ADDR_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clock);
    apb(0, 8'h40, 0);
    chk(rd, 0);
    apb(1, 8'h40, 32'h0000_005A);
    apb(0, 8'h40, 0);
    chk(rd, 32'h0000_005A);
    repeat (2) @(posedge clock);
    chk(cmdMemData, 8'h5A);
    apb(1, ADDR_CTRL, 32'h0000_0002);
    repeat (20) @(posedge clock);
    apb(0, 8'h40, 0);
    chk(rd, 0);
    chk(cmdMemData, 8'h5A);
  endtask

  task s_events;
    mpl_host_model_i.stall <= 1'b1;
    apb(1, ADDR_TAG_LEN, 2);
    apb(1, ADDR_UID0, 32'h0000_BBAA);
    pulse(1'b1);
    pkt(64'h0000_0008_2002_AABB, 5);
    pulse(1'b0);
    pkt(0, 0);
    apb(1, ADDR_EVMASK, 32'h0000_005F);
    ioPin <= 4'h4;
    pkt(64'h0000_0008_0402_AABB, 5);
  endtask

  task s_sleep;
    apb(1, ADDR_ANALOG, 3);
    mpl_host_model_i.send(CMD_SLEEP);
    pkt(64'h0000_0000_0000_0001, 1);
    chk(low_power_indicator_n, 1'b0);
    chk({commEnable, pwmEnable, dac, comp}, 4'h3);
    ioPin <= 4'h0;
    pkt(64'h0000_0008_0402_AABB, 5);
    chk({low_power_indicator_n, commEnable}, 2'h0);
    comparatorOut <= 1'b1;
    pkt(64'h0000_0008_1002_AABB, 5);
    chk(low_power_indicator_n, 1'b0);
    mpl_host_model_i.send(WAKE_BYTE);
    pkt(64'h0000_0000_0000_0001, 1);
    chk(low_power_indicator_n, 1'b1);
    apb(0, ADDR_TAG_LEN, 0);
    chk(rd, 2);
  endtask

  task s_power;
    linkBusy <= 1'b1;
    commandBusy <= 1'b1;
    power_down_request_n <= 1'b0;
    repeat (20) @(posedge clock);
    chk(low_power_indicator_n, 1'b1);
    linkBusy <= 1'b0;
    repeat (10) @(posedge clock);
    chk({low_power_indicator_n, ioHighZ}, 2'h2);
    commandBusy <= 1'b0;
    repeat (10) @(posedge clock);
    chk({low_power_indicator_n, ioHighZ}, 2'h1);
    apb(0, ADDR_STATUS, 0);
    chk(er, 1'b1);
    power_down_request_n <= 1'b1;
    pkt(64'h0000_0000_0000_000F, 1);
    apb(0, ADDR_TAG_LEN, 0);
    chk(rd, 0);
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end

  initial begin
    {rst, power_down_request_n, powerOnReset, psel, penable, pwrite} = 6'b100000;
    {pollingEvent, commandDone, linkBusy, commandBusy, comparatorOut, ioPin, cmdMemAddr} = 13'h0000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    @(posedge clock);
    s_restore;
    s_memory;
    s_events;
    s_sleep;
    s_power;
    final_report;
  end
endmodule

`default_nettype wire
